// ### rtl/windowed_watchdog_timer.sv
/*
 windowed watchdog timer: divided count, refresh window, reset or nmi on fault.
 assumes all control inputs are synchronous to clk_sys_i and the option
 settings are stable from reset onward.
*/
// Summary of operation
// - four timeout lengths, longest by default
// - six clock divider ratios, largest by default
// - window start 25/50/75/100 percent, default none
// - window end 0/25/50/75 percent, default none
// - underflow or bad refresh: reset or nmi
// - low power stop control, halts by default
// - register start or auto start after reset
// - auto start uses option settings, ignores registers
// - valid refresh reloads full timeout
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // option settings
    input  wire logic       auto_start_i,
    input  wire logic [1:0] option_tops_i,
    input  wire logic [2:0] option_cks_i,
    input  wire logic [1:0] option_wst_i,
    input  wire logic [1:0] option_wen_i,
    input  wire logic       option_nmi_i,
    input  wire logic       option_stop_i,
    // software controls
    input  wire logic       cfg_we_i,
    input  wire logic [1:0] cfg_tops_i,
    input  wire logic [2:0] cfg_cks_i,
    input  wire logic [1:0] cfg_wst_i,
    input  wire logic [1:0] cfg_wen_i,
    input  wire logic       cfg_nmi_i,
    input  wire logic       cfg_stop_i,
    input  wire logic       refresh_i,
    input  wire logic       low_power_i,
    input  wire logic       cause_clear_i,
    // status
    output logic [13:0]     count_o,
    output logic            running_o,
    output logic            underflow_flag_o,
    output logic            refresh_err_flag_o,
    output logic            wdt_reset_cause_o,
    // fault outputs
    output logic            chip_reset_req_o,
    output logic            nmi_o
);
    typedef struct packed {
        wdt_pkg::wdt_state_t st;
        wdt_pkg::wdt_cfg_t   reg_cfg;
        logic [13:0]         cnt;
        logic                started;
        logic                unf;
        logic                rerr;
        logic                cause;
        logic                rst_req;
        logic                nmi;
    } core_state_t;

    core_state_t s_r;
    core_state_t s_nxt;
    wdt_pkg::wdt_cfg_t cfg;
    wdt_tick_if tk ();
    logic [13:0] full;
    logic [13:0] win_hi;
    logic [13:0] win_lo;
    logic        in_window;
    logic        count_en;

    // window helpers: quarter points of the current span
    logic [13:0] quarter;
    logic [13:0] half;
    logic [13:0] three_q;
    logic        tick_en;

    // settings in force: option memory wins in auto start
    always_comb begin
        if (auto_start_i) begin
            cfg = '{option_tops_i, option_cks_i, option_wst_i,
                    option_wen_i, option_nmi_i, option_stop_i};
        end else begin
            cfg = s_r.reg_cfg;
        end
    end

    // full count per timeout select
    always_comb begin
        case (cfg.tops)
            wdt_pkg::TOPS_1024: full = wdt_pkg::TOUT_1024;
            wdt_pkg::TOPS_4096: full = wdt_pkg::TOUT_4096;
            wdt_pkg::TOPS_8192: full = wdt_pkg::TOUT_8192;
            default:            full = wdt_pkg::TOUT_16384;
        endcase
    end

    // window bounds in remaining count; full is one below a power of two,
    // so full + 1 splits into exact quarters with no rounding
    always_comb begin
        quarter = 14'(({1'b0, full} + 15'h0001) >> 2);
        half    = quarter + quarter;
        three_q = half + quarter;
        case (cfg.wst)
            wdt_pkg::WST_75: win_hi = three_q;
            wdt_pkg::WST_50: win_hi = half;
            wdt_pkg::WST_25: win_hi = quarter;
            default:         win_hi = full;
        endcase
        case (cfg.wen)
            wdt_pkg::WEN_25: win_lo = three_q;
            wdt_pkg::WEN_50: win_lo = half;
            wdt_pkg::WEN_75: win_lo = quarter;
            default:         win_lo = 14'h0000;
        endcase
        // both bounds inclusive; a start and end that cross leave no legal slot
        in_window = (s_r.cnt <= win_hi) && (s_r.cnt >= win_lo);
    end

    // stop in low power only when the stop setting asks for it
    assign count_en = (s_r.st == wdt_pkg::ST_RUN) && !(low_power_i && cfg.lp_stop);
    assign tk.cks = cfg.cks;
    assign tk.run = count_en;
    // a tick registered just before low power entry is dropped, so the
    // count freezes on the very edge the stop takes hold
    assign tick_en = tk.tick && count_en;

    wdt_prescaler u_div (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tk        (tk)
    );

    // main sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.rst_req = 1'b0;
        s_nxt.nmi = 1'b0;
        if (cause_clear_i) begin
            s_nxt.cause = 1'b0;
        end
        case (s_r.st)
            wdt_pkg::ST_IDLE: begin
                // settings can be rewritten until the counter starts
                if (cfg_we_i && !auto_start_i && !s_r.started) begin
                    s_nxt.reg_cfg = '{cfg_tops_i, cfg_cks_i, cfg_wst_i,
                                      cfg_wen_i, cfg_nmi_i, cfg_stop_i};
                end
                // auto start runs at once; register start waits for refresh
                // a write on the starting edge is kept, but this span uses the old timeout
                if (auto_start_i || refresh_i) begin
                    s_nxt.st = wdt_pkg::ST_RUN;
                    s_nxt.started = 1'b1;
                    s_nxt.cnt = full;
                end
            end
            wdt_pkg::ST_RUN: begin
                // a refresh outranks a tick on the same edge: the reload
                // restarts the span anyway, so the lost tick costs nothing
                if (refresh_i && in_window) begin
                    s_nxt.cnt = full;
                end else if (refresh_i) begin
                    s_nxt.rerr = 1'b1;
                    s_nxt.st = wdt_pkg::ST_TRIP;
                end else if (tick_en && (s_r.cnt == 14'h0000)) begin
                    s_nxt.unf = 1'b1;
                    s_nxt.st = wdt_pkg::ST_TRIP;
                end else if (tick_en) begin
                    s_nxt.cnt = s_r.cnt - 14'h0001;
                end
            end
            wdt_pkg::ST_TRIP: begin
                // one pulse of the selected action, then reload and go on
                // the prescaler is parked here, so the new span starts a whole tick period
                if (cfg.nmi_sel) begin
                    s_nxt.nmi = 1'b1;
                end else begin
                    s_nxt.rst_req = 1'b1;
                    s_nxt.cause = 1'b1;
                end
                s_nxt.cnt = full;
                s_nxt.st = wdt_pkg::ST_RUN;
            end
            default: begin
                s_nxt.st = wdt_pkg::ST_IDLE;
            end
        endcase
    end

    // cause flag sits in this block's own reset domain; the chip reset
    // requested here must not feed reset_i or the flag would be lost
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s_r.st      <= wdt_pkg::ST_IDLE;
            s_r.reg_cfg <= '{wdt_pkg::TOPS_RST, wdt_pkg::CKS_RST, wdt_pkg::WST_RST,
                             wdt_pkg::WEN_RST, wdt_pkg::NMI_RST, wdt_pkg::STOP_RST};
            s_r.cnt     <= 14'h0000;
            s_r.started <= 1'b0;
            s_r.unf     <= 1'b0;
            s_r.rerr    <= 1'b0;
            s_r.cause   <= 1'b0;
            s_r.rst_req <= 1'b0;
            s_r.nmi     <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // status outputs straight from state
    // fault flags stay up until reset_i; only the cause flag has its own clear
    assign count_o            = s_r.cnt;
    assign running_o          = (s_r.st != wdt_pkg::ST_IDLE);
    assign underflow_flag_o   = s_r.unf;
    assign refresh_err_flag_o = s_r.rerr;
    assign wdt_reset_cause_o  = s_r.cause;
    assign chip_reset_req_o   = s_r.rst_req;
    assign nmi_o              = s_r.nmi;
endmodule
`default_nettype wire

// ### rtl/wdt_pkg.sv
/*
 constants and types shared by the windowed watchdog timer files.
 assumes nothing of its surroundings.
*/
package wdt_pkg;
    // timeout select codes, counted in divided ticks
    localparam logic [1:0] TOPS_1024  = 2'h0;
    localparam logic [1:0] TOPS_4096  = 2'h1;
    localparam logic [1:0] TOPS_8192  = 2'h2;
    localparam logic [1:0] TOPS_16384 = 2'h3;
    localparam logic [13:0] TOUT_1024  = 14'h03FF;
    localparam logic [13:0] TOUT_4096  = 14'h0FFF;
    localparam logic [13:0] TOUT_8192  = 14'h1FFF;
    localparam logic [13:0] TOUT_16384 = 14'h3FFF;
    // divider select codes
    localparam logic [2:0] CKS_4    = 3'h0;
    localparam logic [2:0] CKS_64   = 3'h1;
    localparam logic [2:0] CKS_128  = 3'h2;
    localparam logic [2:0] CKS_512  = 3'h3;
    localparam logic [2:0] CKS_2048 = 3'h4;
    localparam logic [2:0] CKS_8192 = 3'h5;
    localparam logic [12:0] DIV_4    = 13'h0003;
    localparam logic [12:0] DIV_64   = 13'h003F;
    localparam logic [12:0] DIV_128  = 13'h007F;
    localparam logic [12:0] DIV_512  = 13'h01FF;
    localparam logic [12:0] DIV_2048 = 13'h07FF;
    localparam logic [12:0] DIV_8192 = 13'h1FFF;
    // window start codes: 100, 75, 50, 25 percent
    localparam logic [1:0] WST_100 = 2'h3;
    localparam logic [1:0] WST_75  = 2'h2;
    localparam logic [1:0] WST_50  = 2'h1;
    localparam logic [1:0] WST_25  = 2'h0;
    // window end codes: 0, 25, 50, 75 percent
    localparam logic [1:0] WEN_0  = 2'h3;
    localparam logic [1:0] WEN_25 = 2'h2;
    localparam logic [1:0] WEN_50 = 2'h1;
    localparam logic [1:0] WEN_75 = 2'h0;
    // reset values of the settings
    localparam logic [1:0] TOPS_RST = TOPS_16384;
    localparam logic [2:0] CKS_RST  = CKS_8192;
    localparam logic [1:0] WST_RST  = WST_100;
    localparam logic [1:0] WEN_RST  = WEN_0;
    localparam logic       NMI_RST  = 1'h0;
    localparam logic       STOP_RST = 1'h1;

    // one full set of watchdog settings
    typedef struct packed {
        logic [1:0] tops;
        logic [2:0] cks;
        logic [1:0] wst;
        logic [1:0] wen;
        logic       nmi_sel;
        logic       lp_stop;
    } wdt_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN  = 2'h1,
        ST_TRIP = 2'h2
    } wdt_state_t;
endpackage

// ### rtl/wdt_tick_if.sv
/*
 tick carrier between the watchdog core and its prescaler.
 assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface wdt_tick_if;
    logic [2:0] cks;
    logic       run;
    logic       tick;
    modport core (output cks, output run, input tick);
    modport div  (input cks, input run, output tick);
endinterface
`default_nettype wire

// ### rtl/wdt_prescaler.sv
/*
 prescaler for the watchdog: one-cycle tick every selected count of clocks.
 assumes select is steady while the counter runs.
*/
`timescale 1ns/10ps
`default_nettype none
module wdt_prescaler (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    // core side
    wdt_tick_if.div   tk
);
    typedef struct packed {
        logic [12:0] cnt;
        logic        tick;
    } div_state_t;

    div_state_t s_r;
    div_state_t s_nxt;
    logic [12:0] lim;

    // terminal count per ratio
    always_comb begin
        case (tk.cks)
            wdt_pkg::CKS_4:    lim = wdt_pkg::DIV_4;
            wdt_pkg::CKS_64:   lim = wdt_pkg::DIV_64;
            wdt_pkg::CKS_128:  lim = wdt_pkg::DIV_128;
            wdt_pkg::CKS_512:  lim = wdt_pkg::DIV_512;
            wdt_pkg::CKS_2048: lim = wdt_pkg::DIV_2048;
            default:           lim = wdt_pkg::DIV_8192;
        endcase
    end

    // held at zero while stopped so each run starts a full tick period
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!tk.run) begin
            s_nxt.cnt = 13'h0000;
        end else if (s_r.cnt >= lim) begin
            s_nxt.cnt = 13'h0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 13'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tk.tick = s_r.tick;
endmodule
`default_nettype wire

// ### dv/windowed_watchdog_timer_checker.sv
/*
 port assertions for the windowed watchdog timer.
 assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer_checker (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    // watched inputs
    input wire logic        auto_start_i,
    input wire logic [1:0]  option_tops_i,
    input wire logic [1:0]  option_wst_i,
    input wire logic [1:0]  option_wen_i,
    input wire logic        option_nmi_i,
    input wire logic        option_stop_i,
    input wire logic        refresh_i,
    input wire logic        low_power_i,
    // watched outputs
    input wire logic [13:0] count_o,
    input wire logic        running_o,
    input wire logic        underflow_flag_o,
    input wire logic        refresh_err_flag_o,
    input wire logic        wdt_reset_cause_o,
    input wire logic        chip_reset_req_o,
    input wire logic        nmi_o
);
    logic [13:0] full_w;
    // reload value implied by the option timeout code
    assign full_w = (option_tops_i == 2'h0) ? wdt_pkg::TOUT_1024 :
                    (option_tops_i == 2'h1) ? wdt_pkg::TOUT_4096 :
                    (option_tops_i == 2'h2) ? wdt_pkg::TOUT_8192 : wdt_pkg::TOUT_16384;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // fault actions are single pulses and never both at once
    chk_rst_pulse: assert property (chip_reset_req_o |=> !chip_reset_req_o)
        else $error("reset request wider than one cycle");
    chk_nmi_pulse: assert property (nmi_o |=> !nmi_o)
        else $error("nmi wider than one cycle");
    chk_one_action: assert property (!(chip_reset_req_o && nmi_o))
        else $error("reset and nmi together");
    chk_fault_follows: assert property (($rose(underflow_flag_o) || $rose(refresh_err_flag_o))
        |-> ##[1:2] (chip_reset_req_o || nmi_o))
        else $error("fault without action");
    chk_uf_sticky: assert property (underflow_flag_o |=> underflow_flag_o)
        else $error("underflow flag dropped");
    chk_cause_set: assert property (chip_reset_req_o |-> ##[0:1] wdt_reset_cause_o)
        else $error("reset cause not set");
    chk_count_step: assert property (running_o && $past(running_o) && count_o < $past(count_o)
        |-> count_o == $past(count_o) - 14'h1)
        else $error("count fell by more than one");
    chk_auto_nmi: assert property (auto_start_i && option_nmi_i |-> !chip_reset_req_o)
        else $error("reset request with option nmi");
    chk_auto_reload: assert property (auto_start_i && option_wst_i == wdt_pkg::WST_100 &&
        option_wen_i == wdt_pkg::WEN_0 && running_o && refresh_i |=> count_o == full_w)
        else $error("refresh did not reload");
    chk_lp_halt: assert property (auto_start_i && option_stop_i && $past(running_o) &&
        $past(low_power_i) && !$past(refresh_i) |-> $stable(count_o))
        else $error("count moved in low power");
    chk_reg_start: assert property (!auto_start_i && !running_o && refresh_i |=> running_o)
        else $error("refresh did not start");
    // main scenarios
    cov_nmi: cover property (nmi_o);
    cov_rst: cover property (chip_reset_req_o);
    cov_err: cover property ($rose(refresh_err_flag_o));
endmodule
bind windowed_watchdog_timer windowed_watchdog_timer_checker chk_inst (.*);
`default_nettype wire

// ### dv/windowed_watchdog_timer_tb.sv
/*
 self-checking bench for the windowed watchdog timer.
 assumes the package is compiled first; drives all inputs on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer_tb;
    logic        clk_sys_i, reset_i, auto_start_i, option_nmi_i, option_stop_i, cfg_we_i;
    logic [1:0]  option_tops_i, option_wst_i, option_wen_i, cfg_tops_i, cfg_wst_i, cfg_wen_i;
    logic [2:0]  option_cks_i, cfg_cks_i;
    logic        cfg_nmi_i, cfg_stop_i, refresh_i, low_power_i, cause_clear_i;
    logic [13:0] count_o, snap;
    logic        running_o, underflow_flag_o, refresh_err_flag_o, wdt_reset_cause_o;
    logic        chip_reset_req_o, nmi_o;
    logic [1:0]  exp_q[$];
    logic [13:0] tout[4] = '{wdt_pkg::TOUT_1024, wdt_pkg::TOUT_4096, wdt_pkg::TOUT_8192,
                             wdt_pkg::TOUT_16384};
    logic [12:0] dv[5] = '{wdt_pkg::DIV_4, wdt_pkg::DIV_64, wdt_pkg::DIV_128,
                           wdt_pkg::DIV_512, wdt_pkg::DIV_2048};
    logic [1:0]  wst[3] = '{wdt_pkg::WST_75, wdt_pkg::WST_25, wdt_pkg::WST_100};
    logic [1:0]  wen[3] = '{wdt_pkg::WEN_50, wdt_pkg::WEN_0, wdt_pkg::WEN_75};
    logic [13:0] ok_at[3] = '{14'h2FF, 14'h0FF, 14'h3F0};
    logic [13:0] bad_at[3] = '{14'h1FF, 14'h3FF, 14'h0FF};
    int          n_errors = 0;
    int          checks = 0;
    integer      seed = 32'hA940;
    windowed_watchdog_timer windowed_watchdog_timer_inst (.*);
    // 100 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic check(input string nm, input logic [13:0] e, input logic [13:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset(input logic a);
        auto_start_i = a;
        reset_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        reset_i = 1'b0;
    endtask
    task automatic cfg(input wdt_pkg::wdt_cfg_t c);
        @(negedge clk_sys_i);
        {cfg_tops_i, cfg_cks_i, cfg_wst_i, cfg_wen_i, cfg_nmi_i, cfg_stop_i} = c;
        cfg_we_i = 1'b1;
        @(negedge clk_sys_i);
        cfg_we_i = 1'b0;
    endtask
    task automatic kick;
        @(negedge clk_sys_i);
        refresh_i = 1'b1;
        @(negedge clk_sys_i);
        refresh_i = 1'b0;
    endtask
    // note the expected action, then wait for a pulse under a bound
    task automatic wait_pulse(input int lim, input logic [1:0] e);
        int i;
        exp_q.push_back(e);
        for (i = 0; i < lim && !(nmi_o || chip_reset_req_o); i++) @(negedge clk_sys_i);
        if (i == lim) begin
            check("timeout", 14'h0, 14'h1);
            end_sim();
        end
        @(negedge clk_sys_i);
    endtask
    task automatic wait_cnt(input logic [13:0] lim);
        int i;
        for (i = 0; i < 20000 && count_o > lim; i++) @(negedge clk_sys_i);
        if (i == 20000) begin
            check("timeout", 14'h0, 14'h1);
            end_sim();
        end
    endtask
    // pulses are matched against the oldest noted action
    always @(negedge clk_sys_i) begin
        if (!reset_i && (nmi_o || chip_reset_req_o)) begin
            check("action", 14'(exp_q.size() ? exp_q[0] : 2'h0),
                  {12'h0, nmi_o, chip_reset_req_o});
            if (exp_q.size()) void'(exp_q.pop_front());
        end
    end
    initial begin
        {auto_start_i, option_tops_i, option_cks_i, option_wst_i, option_wen_i} = 10'h0;
        {option_nmi_i, option_stop_i, low_power_i, cause_clear_i, refresh_i} = 5'h0;
        {cfg_we_i, cfg_tops_i, cfg_cks_i, cfg_wst_i, cfg_wen_i, cfg_nmi_i, cfg_stop_i} = 12'h0;
        do_reset(1'b0);
        check("idle", 14'h0, {count_o[12:0], running_o});
        kick();
        check("count", wdt_pkg::TOUT_16384, count_o);
        repeat (8196) @(negedge clk_sys_i);
        check("count", wdt_pkg::TOUT_16384 - 14'h1, count_o);
        // divider ratios 4 to 2048, each paired with one timeout length
        for (int i = 0; i < 5; i++) begin
            do_reset(1'b0);
            cfg({2'(i), 3'(i), wdt_pkg::WST_100, wdt_pkg::WEN_0, 2'h1});
            kick();
            check("full", tout[i % 4], count_o);
            repeat (3 * (int'(dv[i]) + 1) + int'(dv[i]) / 2) @(negedge clk_sys_i);
            check("ticks", tout[i % 4] - 14'h3, count_o);
        end
        // underflow with reset action, still counting in low power
        do_reset(1'b0);
        cfg({wdt_pkg::TOPS_1024, wdt_pkg::CKS_4, wdt_pkg::WST_100, wdt_pkg::WEN_0, 2'h0});
        low_power_i = 1'b1;
        kick();
        wait_pulse(4200, 2'h1);
        check("flags", 14'h3, {underflow_flag_o, wdt_reset_cause_o});
        @(negedge clk_sys_i) cause_clear_i = 1'b1;
        @(negedge clk_sys_i) cause_clear_i = 1'b0;
        check("cause", 14'h0, wdt_reset_cause_o);
        low_power_i = 1'b0;
        // window start at half: valid refresh, then an early one
        do_reset(1'b0);
        cfg({wdt_pkg::TOPS_1024, wdt_pkg::CKS_4, wdt_pkg::WST_50, wdt_pkg::WEN_0, 2'h3});
        kick();
        wait_cnt(14'h1FF);
        repeat ($random(seed) & 7) @(negedge clk_sys_i);
        kick();
        check("reload", wdt_pkg::TOUT_1024, count_o);
        kick();
        wait_pulse(20, 2'h2);
        check("err", 14'h1, refresh_err_flag_o);
        // window end at a quarter: a late refresh trips
        do_reset(1'b0);
        cfg({wdt_pkg::TOPS_1024, wdt_pkg::CKS_4, wdt_pkg::WST_100, wdt_pkg::WEN_25, 2'h1});
        kick();
        wait_cnt(14'h2FF);
        kick();
        wait_pulse(20, 2'h1);
        // other window codes: refresh inside reloads, outside trips; writes after start refused
        for (int j = 0; j < 3; j++) begin
            do_reset(1'b0);
            cfg({wdt_pkg::TOPS_1024, wdt_pkg::CKS_4, wst[j], wen[j], 2'h3});
            kick();
            cfg({wdt_pkg::TOPS_16384, wdt_pkg::CKS_RST, 6'h0});
            wait_cnt(ok_at[j]);
            kick();
            check("win_ok", wdt_pkg::TOUT_1024, count_o);
            wait_cnt(bad_at[j]);
            kick();
            wait_pulse(20, 2'h2);
        end
        // auto start from the option settings, register writes ignored
        {option_tops_i, option_cks_i, option_wst_i, option_wen_i} = 9'h00F;
        {option_nmi_i, option_stop_i} = 2'h3;
        do_reset(1'b1);
        @(negedge clk_sys_i);
        check("auto", {wdt_pkg::TOUT_1024[12:0], 1'b1}, {count_o[12:0], running_o});
        repeat (4) begin
            @(negedge clk_sys_i);
            {cfg_tops_i, cfg_cks_i, cfg_wst_i, cfg_wen_i, cfg_nmi_i, cfg_stop_i} = 11'($random(seed));
            cfg_we_i = 1'b1;
        end
        @(negedge clk_sys_i) cfg_we_i = 1'b0;
        kick();
        check("reload", wdt_pkg::TOUT_1024, count_o);
        low_power_i = 1'b1;
        snap = count_o;
        repeat (50) @(negedge clk_sys_i);
        check("halt", snap, count_o);
        low_power_i = 1'b0;
        wait_pulse(4200, 2'h2);
        check("queue", 14'h0, 14'(exp_q.size()));
        end_sim();
    end
endmodule
`default_nettype wire
